//--- pcm_port_pkg.sv
// shared constants and state types of the serial pcm port
package pcm_port_pkg;

  // ==========================================================
  // core clock and timing
  localparam int CORE_CLK_MHZ = 250;
  localparam int DECODE_DELAY_NS = 10000;
  localparam int DECODE_DELAY_CYCLES = (DECODE_DELAY_NS * CORE_CLK_MHZ) / 1000;
  localparam int POWERDOWN_DELAY_US = 2000;
  localparam int POWERDOWN_DELAY_CYCLES = POWERDOWN_DELAY_US * CORE_CLK_MHZ;
  localparam int STATIC_LEVEL_US = 20;
  localparam int STATIC_LEVEL_CYCLES = STATIC_LEVEL_US * CORE_CLK_MHZ;
  localparam int DECODE_W = $clog2(DECODE_DELAY_CYCLES + 1);

  // ==========================================================
  // framing
  localparam int SLOT_BITS = 8;
  localparam int LONG_FRAME_MIN_HIGH = 2;
  localparam int T1_FRAME_PULSES = 193;
  localparam int FSX_PULSES_TO_DRIVE = 2;
  localparam int SYNC_STAGES = 3;

  // ==========================================================
  // positions in the synchronised pin vector
  localparam int PIN_TX_BCLK = 0;
  localparam int PIN_TX_FS = 1;
  localparam int PIN_RX_FS = 2;
  localparam int PIN_RX_BCLK = 3;
  localparam int PIN_TX_MCLK = 4;
  localparam int PIN_RX_MCLK = 5;
  localparam int PIN_RX_DATA = 6;
  localparam int PIN_COUNT = 7;

  // ==========================================================
  // state machines
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_ARM = 4'b0010,
    TX_SHIFT = 4'b0100,
    TX_HOLD = 4'b1000
  } tx_state_type;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_SHIFT = 2'b10
  } rx_state_type;

endpackage

//--- pcm_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pcm_pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // pins and filtered levels
  input wire logic [WIDTH-1:0] i_pins,
  output logic [WIDTH-1:0] o_level
);
  logic [WIDTH-1:0] ff1;
  logic [WIDTH-1:0] ff2;
  logic [WIDTH-1:0] ff3;
  logic [WIDTH-1:0] next_level;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("pcm_pin_sync needs WIDTH of at least one");
    end
  endgenerate

  // a bit only moves once stages two and three agree; ff1 feeds ff2 alone
  always_comb begin
    next_level = (ff2 & ff3) | (o_level & (ff2 ^ ff3));
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ff1 <= '0;
      ff2 <= '0;
      ff3 <= '0;
      o_level <= '0;
    end else begin
      ff1 <= i_pins;
      ff2 <= ff1;
      ff3 <= ff2;
      o_level <= next_level;
    end
  end
endmodule

//--- pcm_codec_serial_port.sv
// serial pcm port: framing, shifting, clock selection and power-down
`timescale 1ns/100ps
// Function
// [R1] each transmit sync starts an encode; previous code shifts out on rising bit clock
// [R2] output goes high impedance after eight bit clock periods
// [R3] receive data sampled on falling receive clock, or transmit clock when static
// [R4] far side keeps both syncs synchronous with the master clock in use
// [R5] far side runs master clocks at the documented rates in asynchronous use
// [R6] static receive master pin routes transmit master clock to receive timing
// [R7] with a 193-pulse frame the 193rd master pulse is absorbed
// [R8] far side keeps receive sync synchronous with a running receive bit clock
// [R9] far side keeps bit clocks between 64 kHz and 2.048 MHz
// [R10] short frame mode after reset until long pulses are seen
// [R11] far side makes short sync pulses one bit period wide
// [R12] short mode: enable and sign on next rise, seven more, disable next fall
// [R13] short mode: sign latched next fall, seven more on following falls
// [R14] far side holds long sync pulses three or more bit periods
// [R15] frame mode decided by width of transmit sync pulse
// [R16] far side keeps syncs low at least 160 ns at 64 kHz
// [R17] long mode: drive starts at later of sync rise and clock rise
// [R18] long mode: disable at later of fall after eighth rise and sync low
// [R19] long mode: receive sync rise latches next eight falling edges
// [R20] sync captures the finished code and starts the next conversion
// [R21] decode starts at slot end, decoder output updates 10 us later
// [R22] slot indicator pulled low during the transmit slot
// [R23] power-down 2 ms after last transmit sync once both syncs stay low
// [R24] output stays high impedance until the second transmit sync after power-up
// [R25] static receive clock pin level selects master divider, tx clock serves both
module pcm_codec_serial_port
  import pcm_port_pkg::*;
#(
  parameter int STATIC_CYCLES = STATIC_LEVEL_CYCLES,
  parameter int POWERDOWN_CYCLES = POWERDOWN_DELAY_CYCLES,
  parameter logic ALAW_VARIANT = 1'b1
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // link pins
  input wire logic i_tx_bit_clock,
  input wire logic i_tx_frame_sync,
  input wire logic i_rx_frame_sync,
  input wire logic i_rx_bit_clock_or_freq_select,
  input wire logic i_tx_master_clock,
  input wire logic i_rx_master_clock_or_powerdown,
  input wire logic i_rx_data,
  output logic o_tx_data,
  output logic o_tx_data_oe_n,
  output logic o_tx_slot_indicator,
  output logic o_tx_slot_indicator_oe_n,
  // encoder side
  input wire logic [SLOT_BITS-1:0] i_tx_code,
  output logic o_encode_start,
  // decoder side
  output logic [SLOT_BITS-1:0] o_rx_code,
  output logic o_decode_start,
  output logic o_decoder_update,
  // status and internal timing
  output logic o_powered_down,
  output logic o_long_frame,
  output logic o_sync_mode,
  output logic o_master_2048,
  output logic o_master_from_tx,
  output logic o_master_tick,
  output logic o_rx_master_tick
);
  localparam int SW = $clog2(STATIC_CYCLES + 1);
  localparam int PW = $clog2(POWERDOWN_CYCLES + 1);

  generate
    if (STATIC_CYCLES < 1 || POWERDOWN_CYCLES < 1) begin : g_bad_counts
      $error("pcm_codec_serial_port counts must be at least one");
    end
  endgenerate

  // ==========================================================
  // pin synchronisation and edges
  logic [PIN_COUNT-1:0] pins;
  logic [PIN_COUNT-1:0] pins_d;
  logic [PIN_COUNT-1:0] rise;
  logic [PIN_COUNT-1:0] fall;

  pcm_pin_sync #(.WIDTH(PIN_COUNT)) u_sync (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_pins({i_rx_data, i_rx_master_clock_or_powerdown, i_tx_master_clock,
             i_rx_bit_clock_or_freq_select, i_rx_frame_sync, i_tx_frame_sync,
             i_tx_bit_clock}),
    .o_level(pins)
  );

  assign rise = pins & ~pins_d;
  assign fall = ~pins & pins_d;

  function automatic logic [SW-1:0] idle_count(input logic [SW-1:0] cnt, input logic edge_seen);
    if (edge_seen) begin
      idle_count = '0;
    end else if (cnt == SW'(STATIC_CYCLES)) begin
      idle_count = cnt;
    end else begin
      idle_count = cnt + SW'(1);
    end
  endfunction

  // ==========================================================
  // state
  tx_state_type tx_state, next_tx_state;
  rx_state_type rx_state, next_rx_state;
  logic [SW-1:0] rbclk_idle, next_rbclk_idle;
  logic [SW-1:0] rmclk_idle, next_rmclk_idle;
  logic [PW-1:0] pd_cnt, next_pd_cnt;
  logic [DECODE_W-1:0] dec_cnt, next_dec_cnt;
  logic [SLOT_BITS-1:0] tx_shift, next_tx_shift;
  logic [SLOT_BITS-1:0] rx_shift, next_rx_shift;
  logic [3:0] tx_bits, next_tx_bits;
  logic [3:0] rx_bits, next_rx_bits;
  logic [1:0] fs_high, next_fs_high;
  logic [1:0] fsx_pulses, next_fsx_pulses;
  logic [7:0] mclk_cnt, next_mclk_cnt;
  logic absorb, next_absorb;
  logic next_tx_data, next_tx_oe_n, next_slot_oe_n, next_encode_start;
  logic [SLOT_BITS-1:0] next_rx_code;
  logic next_decode_start, next_decoder_update, next_powered_down, next_long_frame;
  logic next_master_tick, next_rx_master_tick;
  logic rbclk_run, rmclk_run, rb_fall, pd_now, drive_ok;

  always_comb begin
    next_rbclk_idle = idle_count(rbclk_idle, rise[PIN_RX_BCLK] | fall[PIN_RX_BCLK]);
    next_rmclk_idle = idle_count(rmclk_idle, rise[PIN_RX_MCLK] | fall[PIN_RX_MCLK]);
    rbclk_run = rbclk_idle != SW'(STATIC_CYCLES);
    rmclk_run = rmclk_idle != SW'(STATIC_CYCLES);
    // receive shifts on its own clock only while it runs
    rb_fall = rbclk_run ? fall[PIN_RX_BCLK] : fall[PIN_TX_BCLK]; // [R3] [R8] [R25]
    drive_ok = fsx_pulses >= 2'(FSX_PULSES_TO_DRIVE);

    // power-down by quiet syncs or static high receive master pin
    if (pins[PIN_TX_FS] | pins[PIN_RX_FS]) begin
      next_pd_cnt = '0;
    end else if (pd_cnt != PW'(POWERDOWN_CYCLES)) begin
      next_pd_cnt = pd_cnt + PW'(1);
    end else begin
      next_pd_cnt = pd_cnt;
    end
    pd_now = (pd_cnt == PW'(POWERDOWN_CYCLES)) | (~rmclk_run & pins[PIN_RX_MCLK]); // [R23]
    next_powered_down = pd_now;

    // the pulse that wakes the device counts as the first one
    next_fsx_pulses = fsx_pulses;
    if (o_powered_down && !pins[PIN_TX_FS]) begin
      next_fsx_pulses = '0;
    end else if (rise[PIN_TX_FS] && !drive_ok) begin
      next_fsx_pulses = fsx_pulses + 2'(1); // [R24]
    end

    // framing width from the transmit sync
    next_fs_high = fs_high;
    next_long_frame = o_long_frame;
    if (fall[PIN_TX_FS]) begin
      next_long_frame = fs_high >= 2'(LONG_FRAME_MIN_HIGH); // [R15] [R10] [R11] [R14]
      next_fs_high = '0;
    end else if (fall[PIN_TX_BCLK] && pins[PIN_TX_FS] && fs_high != 2'd3) begin
      next_fs_high = fs_high + 2'(1);
    end

    // master clock per frame, drop the extra pulse of a 193-pulse frame
    next_mclk_cnt = mclk_cnt;
    next_absorb = absorb;
    if (rise[PIN_TX_FS]) begin
      next_absorb = mclk_cnt == 8'(T1_FRAME_PULSES); // [R7]
      next_mclk_cnt = {7'h00, rise[PIN_TX_MCLK]};
    end else if (rise[PIN_TX_MCLK] && mclk_cnt != 8'hff) begin
      next_mclk_cnt = mclk_cnt + 8'(1);
    end
    next_master_tick = rise[PIN_TX_MCLK] & ~(absorb & mclk_cnt == 8'(T1_FRAME_PULSES - 1)); // [R7]
    next_rx_master_tick = rmclk_run ? rise[PIN_RX_MCLK] : next_master_tick; // [R6]

    // transmit slot
    next_tx_state = tx_state;
    next_tx_shift = tx_shift;
    next_tx_bits = tx_bits;
    next_tx_data = o_tx_data;
    next_tx_oe_n = o_tx_data_oe_n;
    next_encode_start = 1'b0;
    case (tx_state)
      TX_IDLE: begin
        if (!o_powered_down && ((!o_long_frame && fall[PIN_TX_BCLK] && pins[PIN_TX_FS]) ||
            (o_long_frame && rise[PIN_TX_FS]))) begin
          next_tx_shift = i_tx_code; // [R1] [R20]
          next_encode_start = 1'b1; // [R20]
          next_tx_state = TX_ARM;
          if (o_long_frame && pins[PIN_TX_BCLK]) begin
            // clock already high: the sync edge is the later one
            next_tx_state = TX_SHIFT; // [R17]
            next_tx_data = i_tx_code[SLOT_BITS-1];
            next_tx_shift = {i_tx_code[SLOT_BITS-2:0], 1'b0};
            next_tx_bits = 4'd1;
            // count of this very pulse is not registered yet
            next_tx_oe_n = next_fsx_pulses < 2'(FSX_PULSES_TO_DRIVE); // [R24]
          end
        end
      end
      TX_ARM: begin
        if (rise[PIN_TX_BCLK]) begin
          next_tx_state = TX_SHIFT; // [R12] [R17]
          next_tx_data = tx_shift[SLOT_BITS-1];
          next_tx_shift = {tx_shift[SLOT_BITS-2:0], 1'b0};
          next_tx_bits = 4'd1;
          next_tx_oe_n = ~drive_ok; // [R24]
        end
      end
      TX_SHIFT: begin
        if (rise[PIN_TX_BCLK] && tx_bits != 4'(SLOT_BITS)) begin
          next_tx_data = tx_shift[SLOT_BITS-1]; // [R1] [R12] [R17]
          next_tx_shift = {tx_shift[SLOT_BITS-2:0], 1'b0};
          next_tx_bits = tx_bits + 4'(1);
        end else if (fall[PIN_TX_BCLK] && tx_bits == 4'(SLOT_BITS)) begin
          if (o_long_frame && pins[PIN_TX_FS]) begin
            next_tx_state = TX_HOLD; // [R18]
          end else begin
            next_tx_state = TX_IDLE; // [R2] [R12]
            next_tx_oe_n = 1'b1;
          end
        end
      end
      TX_HOLD: begin
        if (!pins[PIN_TX_FS]) begin
          next_tx_state = TX_IDLE; // [R18]
          next_tx_oe_n = 1'b1;
        end
      end
      default: begin
        next_tx_state = TX_IDLE;
        next_tx_oe_n = 1'b1;
      end
    endcase
    if (o_powered_down) begin
      next_tx_state = TX_IDLE;
      next_tx_oe_n = 1'b1;
    end
    next_slot_oe_n = ~(next_tx_state == TX_SHIFT || next_tx_state == TX_HOLD); // [R22]

    // receive slot and decode timing
    next_rx_state = rx_state;
    next_rx_shift = rx_shift;
    next_rx_bits = rx_bits;
    next_decode_start = 1'b0;
    next_decoder_update = 1'b0;
    next_rx_code = o_rx_code;
    next_dec_cnt = dec_cnt;
    if (dec_cnt != '0) begin
      next_dec_cnt = dec_cnt - DECODE_W'(1);
      if (dec_cnt == DECODE_W'(1)) begin
        next_rx_code = rx_shift; // [R21]
        next_decoder_update = 1'b1;
      end
    end
    case (rx_state)
      RX_IDLE: begin
        if (!o_powered_down && ((!o_long_frame && rb_fall && pins[PIN_RX_FS]) ||
            (o_long_frame && rise[PIN_RX_FS]))) begin
          next_rx_state = RX_SHIFT; // [R13] [R19]
          next_rx_bits = '0;
        end
      end
      RX_SHIFT: begin
        if (rb_fall) begin
          next_rx_shift = {rx_shift[SLOT_BITS-2:0], pins[PIN_RX_DATA]}; // [R3] [R13] [R19]
          next_rx_bits = rx_bits + 4'(1);
          if (rx_bits == 4'(SLOT_BITS - 1)) begin
            next_rx_state = RX_IDLE;
            next_decode_start = 1'b1; // [R21]
            next_dec_cnt = DECODE_W'(DECODE_DELAY_CYCLES);
          end
        end
      end
      default: begin
        next_rx_state = RX_IDLE;
      end
    endcase
    if (o_powered_down) begin
      next_rx_state = RX_IDLE;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pins_d <= '0;
      tx_state <= TX_IDLE;
      rx_state <= RX_IDLE;
      rbclk_idle <= '0;
      rmclk_idle <= '0;
      pd_cnt <= PW'(POWERDOWN_CYCLES);
      dec_cnt <= '0;
      tx_shift <= '0;
      rx_shift <= '0;
      tx_bits <= '0;
      rx_bits <= '0;
      fs_high <= '0;
      fsx_pulses <= '0;
      mclk_cnt <= '0;
      absorb <= 1'b0;
      o_tx_data <= 1'b0;
      o_tx_data_oe_n <= 1'b1;
      o_tx_slot_indicator <= 1'b0;
      o_tx_slot_indicator_oe_n <= 1'b1;
      o_encode_start <= 1'b0;
      o_rx_code <= '0;
      o_decode_start <= 1'b0;
      o_decoder_update <= 1'b0;
      o_powered_down <= 1'b1;
      o_long_frame <= 1'b0; // [R10]
      o_sync_mode <= 1'b0;
      o_master_2048 <= 1'b0;
      o_master_from_tx <= 1'b0;
      o_master_tick <= 1'b0;
      o_rx_master_tick <= 1'b0;
    end else begin
      pins_d <= pins;
      tx_state <= next_tx_state;
      rx_state <= next_rx_state;
      rbclk_idle <= next_rbclk_idle;
      rmclk_idle <= next_rmclk_idle;
      pd_cnt <= next_pd_cnt;
      dec_cnt <= next_dec_cnt;
      tx_shift <= next_tx_shift;
      rx_shift <= next_rx_shift;
      tx_bits <= next_tx_bits;
      rx_bits <= next_rx_bits;
      fs_high <= next_fs_high;
      fsx_pulses <= next_fsx_pulses;
      mclk_cnt <= next_mclk_cnt;
      absorb <= next_absorb;
      o_tx_data <= next_tx_data;
      o_tx_data_oe_n <= next_tx_oe_n;
      o_tx_slot_indicator <= 1'b0;
      o_tx_slot_indicator_oe_n <= next_slot_oe_n;
      o_encode_start <= next_encode_start;
      o_rx_code <= next_rx_code;
      o_decode_start <= next_decode_start;
      o_decoder_update <= next_decoder_update;
      o_powered_down <= next_powered_down;
      o_long_frame <= next_long_frame;
      o_sync_mode <= ~rbclk_run; // [R25]
      o_master_2048 <= (rbclk_run | pins[PIN_RX_BCLK]) ? ALAW_VARIANT : ~ALAW_VARIANT; // [R25]
      o_master_from_tx <= ~rmclk_run; // [R6]
      o_master_tick <= next_master_tick;
      o_rx_master_tick <= next_rx_master_tick;
    end
  end
endmodule

//--- pcm_port_sva.sv
// assertion checker for the serial pcm port
`timescale 1ns/100ps
module pcm_port_sva
  import pcm_port_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // watched pins and status
  input wire logic i_tx_bit_clock,
  input wire logic i_tx_frame_sync,
  input wire logic o_tx_data_oe_n,
  input wire logic o_tx_slot_indicator,
  input wire logic o_tx_slot_indicator_oe_n,
  input wire logic o_encode_start,
  input wire logic o_decode_start,
  input wire logic o_decoder_update,
  input wire logic o_powered_down,
  input wire logic o_long_frame,
  input wire logic o_master_from_tx,
  input wire logic o_master_tick,
  input wire logic o_rx_master_tick
);
  // ==========
  // helper counters
  logic bclk_q;
  logic [3:0] rises;
  logic [11:0] dly;
  // rises seen while driving: the first rise lands before enable, so a slot counts seven
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bclk_q <= 1'b0;
      rises <= 4'h0;
      dly <= 12'h000;
    end else begin
      bclk_q <= i_tx_bit_clock;
      if (o_tx_data_oe_n)
        rises <= 4'h0;
      else if (i_tx_bit_clock && !bclk_q)
        rises <= rises + 4'h1;
      if (o_decode_start)
        dly <= 12'(DECODE_DELAY_CYCLES);
      else if (dly != 12'h000)
        dly <= dly - 12'h001;
    end
  end

  // ==========
  // properties
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  decode_delay_a: assert property ((dly == 12'h001) == o_decoder_update)
    else $error("decoder update off its fixed delay");
  drive_bits_a: assert property ($rose(o_tx_data_oe_n) |-> rises == 4'h7)
    else $error("drive window not eight bit periods");
  slot_cover_a: assert property (!o_tx_data_oe_n |-> !o_tx_slot_indicator_oe_n)
    else $error("slot indicator released while driving");
  slot_low_a: assert property (!o_tx_slot_indicator)
    else $error("slot indicator value not low");
  pd_quiet_a: assert property (o_powered_down |-> o_tx_data_oe_n && o_tx_slot_indicator_oe_n)
    else $error("pins driven while powered down");
  enc_start_a: assert property (o_encode_start |-> i_tx_frame_sync ##1 !o_encode_start)
    else $error("encode start outside sync or too long");
  mode_fall_a: assert property ($changed(o_long_frame) |-> !i_tx_frame_sync)
    else $error("frame mode changed while sync high");
  rx_route_a: assert property (o_master_from_tx |-> o_rx_master_tick == o_master_tick)
    else $error("receive timing not from transmit master");
  long_c: cover property ($rose(o_long_frame));
  update_c: cover property (o_decoder_update);
  pd_c: cover property ($rose(o_powered_down));
  drive_c: cover property ($rose(o_tx_data_oe_n));
endmodule

//--- pcm_highway_model.sv
// far-side highway controller model: bit clock, syncs and receive data
`timescale 1ns/100ps
module pcm_highway_model (
  // pacing clock
  input wire logic i_core_clk,
  // port pins
  output logic o_bclk,
  output logic o_tx_fs,
  output logic o_rx_fs,
  output logic o_rx_data,
  input wire logic i_tx_data,
  input wire logic i_tx_data_oe_n
);
  logic [5:0] cnt = 6'h00;
  logic bclk = 1'b0;
  assign o_bclk = bclk;
  initial begin
    o_tx_fs = 1'b0;
    o_rx_fs = 1'b0;
    o_rx_data = 1'b1;
  end

  // ==========
  // bit clock
  // 248 ns half period keeps it just under 2.048 MHz
  always @(negedge i_core_clk) begin
    if (cnt == 6'h3d) begin
      cnt <= 6'h00;
      bclk <= ~bclk;
    end else begin
      cnt <= cnt + 6'h01;
    end
  end

  // ==========
  // one frame; sync edges ride on bit clock edges, which also feeds the master pin
  task automatic frame(input bit lng, input bit nrx, input logic [7:0] rxb,
                       output logic [7:0] txb, output bit drv);
    drv = 1'b1;
    if (lng) begin
      @(negedge bclk);
      o_tx_fs = 1'b1;
      o_rx_fs = !nrx;
      o_rx_data = rxb[7];
    end else begin
      @(posedge bclk);
      o_tx_fs = 1'b1;
      o_rx_fs = !nrx;
    end
    for (int i = 7; i >= 0; i--) begin
      @(posedge bclk);
      if (i == (lng ? 4 : 7)) begin
        o_tx_fs = 1'b0;
        o_rx_fs = 1'b0;
      end
      o_rx_data = rxb[i];
      @(negedge bclk);
      txb[i] = i_tx_data;
      drv &= !i_tx_data_oe_n;
    end
    @(posedge bclk);
    o_rx_data = ~rxb[0];
  endtask
endmodule

//--- tb_top.sv
// self-checking testbench of the serial pcm port
`timescale 1ns/100ps
module tb_top;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic freq_sel = 1'b1;
  logic rx_mclk = 1'b0;
  logic [7:0] tx_code = 8'h00;
  logic bclk, tx_fs, rx_fs, rx_data, tx_data, tx_oe_n;
  logic enc_start, dec_upd, pd, long_fr, from_tx, sync_md, m2048;
  logic [7:0] rx_code;
  logic [7:0] got;
  bit drv;
  int err_total = 0;
  int compares = 0;

  // ==========
  // clock, design and far side
  always #2 core_clk = ~core_clk;

  pcm_codec_serial_port #(.STATIC_CYCLES(50), .POWERDOWN_CYCLES(10000)) i_dut (
    .i_core_clk(core_clk), .i_sys_rst(sys_rst),
    .i_tx_bit_clock(bclk), .i_tx_frame_sync(tx_fs), .i_rx_frame_sync(rx_fs),
    .i_rx_bit_clock_or_freq_select(freq_sel), .i_tx_master_clock(bclk),
    .i_rx_master_clock_or_powerdown(rx_mclk), .i_rx_data(rx_data),
    .o_tx_data(tx_data), .o_tx_data_oe_n(tx_oe_n), .o_tx_slot_indicator(),
    .o_tx_slot_indicator_oe_n(), .i_tx_code(tx_code), .o_encode_start(enc_start),
    .o_rx_code(rx_code), .o_decode_start(), .o_decoder_update(dec_upd),
    .o_powered_down(pd), .o_long_frame(long_fr), .o_sync_mode(sync_md),
    .o_master_2048(m2048), .o_master_from_tx(from_tx), .o_master_tick(),
    .o_rx_master_tick());

  pcm_highway_model i_hw (.i_core_clk(core_clk), .o_bclk(bclk), .o_tx_fs(tx_fs),
    .o_rx_fs(rx_fs), .o_rx_data(rx_data), .i_tx_data(tx_data), .i_tx_data_oe_n(tx_oe_n));

  // encoder moves on right after capture, so a late capture shows the wrong code
  always @(negedge core_clk) begin
    if (enc_start === 1'b1)
      tx_code <= ~tx_code;
  end

  // ==========
  // compare and closing tasks
  task automatic chk1(input string what, input logic exp, input logic seen);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] seen);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_for(input string what, ref logic flag, input int lim);
    int n;
    n = 0;
    while (flag !== 1'b1 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= lim) begin
      err_total++;
      $display("BAD %s expected 1 seen timeout", what);
      conclude();
    end
  endtask
  task automatic xfer(input bit lng, input logic [7:0] rxb, input logic [7:0] code);
    tx_code = code;
    i_hw.frame(lng, 1'b0, rxb, got, drv);
    chk1("drive", 1'b1, drv);
    chk8("tx code", code, got);
    wait_for("decoder update", dec_upd, 3000);
    chk8("rx code", rxb, rx_code);
  endtask

  // ==========
  // scenarios
  task automatic t_power_up();
    chk1("powered down", 1'b1, pd);
    chk1("long mode", 1'b0, long_fr);
    i_hw.frame(1'b0, 1'b1, 8'h00, got, drv);
    chk1("first slot drive", 1'b0, drv);
    chk1("master from tx", 1'b1, from_tx);
    chk1("sync mode", 1'b1, sync_md);
    chk1("master 2048", 1'b1, m2048);
    $display("test power up done");
  endtask
  task automatic t_short();
    xfer(1'b0, 8'ha5, 8'h81);
    xfer(1'b0, 8'h5a, 8'h7e);
    chk1("long mode", 1'b0, long_fr);
    $display("test short frame done");
  endtask
  task automatic t_long();
    i_hw.frame(1'b1, 1'b1, 8'h00, got, drv);
    chk1("long mode", 1'b1, long_fr);
    xfer(1'b1, 8'hc3, 8'h0f);
    $display("test long frame done");
  endtask
  task automatic t_back_short();
    i_hw.frame(1'b0, 1'b1, 8'h00, got, drv);
    chk1("long mode", 1'b0, long_fr);
    xfer(1'b0, 8'h96, 8'hf0);
    $display("test back to short done");
  endtask
  task automatic t_power_down();
    repeat (5000) @(negedge core_clk);
    chk1("early power down", 1'b0, pd);
    wait_for("power down", pd, 3000);
    rx_mclk = 1'b1;
    i_hw.frame(1'b0, 1'b1, 8'h00, got, drv);
    chk1("drive while held down", 1'b0, drv);
    chk1("held down", 1'b1, pd);
    rx_mclk = 1'b0;
    $display("test power down done");
  endtask

  initial begin
    repeat (20) @(negedge core_clk);
    sys_rst = 1'b0;
    t_power_up();
    t_short();
    t_long();
    t_back_short();
    t_power_down();
    conclude();
  end
endmodule

bind pcm_codec_serial_port pcm_port_sva i_chk (.i_core_clk, .i_sys_rst, .i_tx_bit_clock,
  .i_tx_frame_sync, .o_tx_data_oe_n, .o_tx_slot_indicator, .o_tx_slot_indicator_oe_n,
  .o_encode_start, .o_decode_start, .o_decoder_update, .o_powered_down, .o_long_frame,
  .o_master_from_tx, .o_master_tick, .o_rx_master_tick);
